// >>> sar_conversion_sequencer.sv
// Successive-approximation conversion sequencer with gated bit clock.
`timescale 1ns/1ps
`default_nettype none
`include "sar_seq_consts.svh"

module sar_conversion_sequencer #(
    parameter int unsigned BITS       = `SAR_BITS,
    parameter int unsigned HALF_CYC   = `SAR_BIT_PERIOD_CYC / 2,
    parameter int unsigned STOP_CYC   = `SAR_STOP_DELAY_CYC
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_nrst,
    input  wire logic                     i_convert_start,
    input  wire logic                     i_comp_keep,
    input  wire logic                     i_early_stop,
    output var  sar_seq_pkg::result_bus_t o_result,
    output logic [11:0]                   o_dac_trial,
    output logic                          o_gated_clk,
    output logic                          o_busy
);
    localparam logic [3:0] LAST_STEP = 4'(BITS);
    localparam logic [3:0] CYC_LAST  = 4'(`SAR_GATED_CYCLES);
    localparam logic [7:0] HALF_W    = 8'(HALF_CYC);
    localparam logic [7:0] STOP_W    = 8'(STOP_CYC);
    // An early stop is seen one cycle after its decision, so its tail starts one count on.
    localparam logic [7:0] EARLY_TAIL = (STOP_W > 8'h01) ? 8'h01 : 8'h00;

    typedef struct packed {
        sar_seq_pkg::seq_state_t fsm;
        logic                    start_prev;
        logic [11:0]             sar;        // Pin-form register, bit 11 is MSB, low means one.
        logic [12:0]             shift;      // Marker shift register, zero-filled, one position per step.
        logic [3:0]              step;       // Current bit under test, 0 before first.
        logic [3:0]              cycles;     // Gated clock cycles elapsed.
        logic [7:0]              phase;      // Sysclock count within half a gated cycle.
        logic                    clk_lvl;
        logic                    inhibit;
        logic                    busy;
        logic [7:0]              tail;
        logic [11:0]             data_n;
        logic                    msb_inv;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic        start_lvl;

    // Start pin is asynchronous to the system clock.
    sar_sync3 u_start_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_async   (i_convert_start),
        .o_level   (start_lvl)
    );

    // Main sequencer: all state advances here once per system clock.
    always_comb begin
        next_st            = st;
        next_st.start_prev = start_lvl;

        unique case (st.fsm)
            sar_seq_pkg::ST_IDLE, sar_seq_pkg::ST_TAIL: begin
                if (st.start_prev && !start_lvl) begin
                    next_st.fsm  = sar_seq_pkg::ST_ARMED;
                    next_st.busy = 1'b1;
                end
            end
            sar_seq_pkg::ST_ARMED: begin
                if (start_lvl) begin
                    next_st.fsm     = sar_seq_pkg::ST_CONV;
                    next_st.inhibit = 1'b0;
                    next_st.sar     = `SAR_RESULT_RESET;
                    next_st.shift   = 13'h0001;
                    next_st.step    = 4'h0;
                    next_st.cycles  = 4'h0;
                    next_st.phase   = 8'h00;
                    next_st.clk_lvl = 1'b0;
                end
            end
            sar_seq_pkg::ST_CONV: begin
                if (st.clk_lvl && st.phase == 8'h00 && st.step != 4'h0 && !i_early_stop) begin
                    next_st.fsm  = sar_seq_pkg::ST_TAIL;
                    next_st.tail = EARLY_TAIL;
                end else if (st.phase == HALF_W - 8'h01) begin
                    next_st.phase   = 8'h00;
                    next_st.clk_lvl = ~st.clk_lvl;
                    if (!st.clk_lvl) begin
                        if (st.step == 4'h0) begin
                            next_st.sar = 12'h7FF;
                        end else begin
                            // MSB toward LSB
                            // A kept bit drives its pin low, as the outputs are negative-true.
                            next_st.sar[12 - st.step] = ~i_comp_keep;
                            if (st.step < LAST_STEP) begin
                                next_st.sar[11 - st.step] = 1'b0;
                            end
                        end
                        next_st.step   = st.step + 4'h1;
                        next_st.cycles = st.cycles + 4'h1;
                        // thirteen gated cycles
                        // The last pulse stays high until the inhibit returns with busy low.
                        if (st.step == LAST_STEP || st.cycles == CYC_LAST - 4'h1) begin
                            next_st.fsm  = sar_seq_pkg::ST_TAIL;
                            next_st.tail = 8'h00;
                        end
                    end else begin
                        next_st.shift = {st.shift[11:0], 1'b0};
                    end
                end else begin
                    next_st.phase = st.phase + 8'h01;
                end
            end
        endcase

        if (st.fsm == sar_seq_pkg::ST_TAIL && st.busy) begin
            if (st.tail == STOP_W - 8'h01) begin
                next_st.busy = 1'b0;
                next_st.inhibit = 1'b1;
                next_st.fsm = sar_seq_pkg::ST_IDLE;
            end else begin
                next_st.tail = st.tail + 8'h01;
            end
        end

        next_st.data_n  = next_st.sar;
        next_st.msb_inv = ~next_st.sar[11];
    end

    // Synchronous reset puts the block idle with clock inhibited.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            st            <= '0;
            st.fsm        <= sar_seq_pkg::ST_IDLE;
            st.start_prev <= 1'b1;
            st.inhibit    <= 1'b1;
            st.sar        <= `SAR_RESULT_RESET;
            st.data_n     <= `SAR_RESULT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_busy           = st.busy;
    assign o_gated_clk      = st.clk_lvl & ~st.inhibit;
    // The converter side wants the trial in true form.
    assign o_dac_trial      = ~st.sar;
    assign o_result.data_n  = st.data_n;
    assign o_result.msb_inv = st.msb_inv;
    assign o_result.busy    = st.busy;
endmodule
`default_nettype wire

// >>> sar_seq_consts.svh
// Timing counts, bit widths and reset values of the conversion sequencer.
`ifndef SAR_SEQ_CONSTS_SVH
`define SAR_SEQ_CONSTS_SVH

`define SAR_CLK_PERIOD_PS       25000
`define SAR_BITS                12
`define SAR_GATED_CYCLES        13
`define SAR_STOP_DELAY_NS       40
`define SAR_STOP_DELAY_CYC      (((`SAR_STOP_DELAY_NS * 1000) + `SAR_CLK_PERIOD_PS - 1) / `SAR_CLK_PERIOD_PS)
`define SAR_LSB_LEAD_NS         20
`define SAR_START_MIN_NS        100
`define SAR_START_MIN_CYC       (((`SAR_START_MIN_NS * 1000) + `SAR_CLK_PERIOD_PS - 1) / `SAR_CLK_PERIOD_PS)
`define SAR_BIT_PERIOD_CYC      12
`define SAR_MAX_CONV_12_NS      10000
`define SAR_MAX_CONV_10_NS      8500
`define SAR_MAX_CONV_8_NS       6800
`define SAR_RESULT_RESET        12'hFFF
`define SAR_DELAY_W             8

`endif

// >>> sar_seq_pkg.sv
// Types shared by the conversion sequencer files.
package sar_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_CONV  = 2'b10,
        ST_TAIL  = 2'b11
    } seq_state_t;

    // Result pins as driven toward the host.
    typedef struct packed {
        logic [11:0] data_n;
        logic        msb_inv;
        logic        busy;
    } result_bus_t;

endpackage

// >>> sar_sync3.sv
// Three-stage synchroniser for one asynchronous pin, with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module sar_sync3 (
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_async,
    output var  logic o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // The first stage feeds only the second; the filter looks at stages two and three.
    always_comb begin
        next_st     = st;
        next_st.s1  = i_async;
        next_st.s2  = st.s1;
        next_st.s3  = st.s2;
        if (st.s2 == st.s3) begin
            next_st.lvl = st.s3;
        end
    end

    // Start pin idles high, so the filtered level resets high.
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            st <= 4'hF;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.lvl;
endmodule
`default_nettype wire

// >>> sar_seq_assertions.sv
// Port-level property checker for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module sar_seq_checker (
    input wire logic                     i_clk_sys,
    input wire logic                     i_nrst,
    input wire logic                     i_convert_start,
    input wire logic                     i_early_stop,
    input wire sar_seq_pkg::result_bus_t o_result,
    input wire logic [11:0]              o_dac_trial,
    input wire logic                     o_gated_clk,
    input wire logic                     o_busy
);
    logic [4:0] rises;
    logic       clk_q;

    // Gated clock rises per conversion; cleared while idle so each run counts afresh.
    always_ff @(posedge i_clk_sys) begin
        clk_q <= o_gated_clk;
        if (!i_nrst || !o_busy) rises <= 5'h00;
        else if (o_gated_clk && !clk_q) rises <= rises + 5'h01;
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    // A start held low long enough to pass the pin filter.
    sequence start_held;
        $fell(i_convert_start) ##1 (!i_convert_start) [*7];
    endsequence
    sequence start_taken;
        $rose(i_convert_start) && o_busy;
    endsequence

    start_busy_a: assert property (start_held |-> o_busy)
        else $error("busy not raised by start");
    clk_count_a: assert property ($fell(o_busy) && i_early_stop |-> rises == 5'h0D)
        else $error("gated clock cycle count wrong");
    first_step_a: assert property (start_taken |-> ##[1:20] o_dac_trial == 12'h800)
        else $error("first trial pattern missing");
    data_hold_a: assert property (!o_busy && !$past(o_busy) |-> $stable(o_result.data_n))
        else $error("result moved while idle");
    gate_low_a: assert property (!o_busy |-> !o_gated_clk)
        else $error("gated clock runs while idle");
    conv_time_a: assert property (start_taken |-> ##[1:400] !o_busy)
        else $error("conversion too long");
    msb_copy_a: assert property (o_result.msb_inv == ~o_result.data_n[11])
        else $error("inverted msb copy wrong");
    clk_half_a: assert property ($rose(o_gated_clk) |-> (o_gated_clk || !o_busy) [*6])
        else $error("gated clock high phase short");
    busy_hold_a: assert property ($rose(o_busy) |-> o_busy [*8])
        else $error("busy dropped early");
    busy_copy_a: assert property (o_result.busy == o_busy)
        else $error("busy copies disagree");
endmodule

bind sar_conversion_sequencer sar_seq_checker u_chk (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_convert_start(i_convert_start),
    .i_early_stop(i_early_stop), .o_result(o_result), .o_dac_trial(o_dac_trial),
    .o_gated_clk(o_gated_clk), .o_busy(o_busy));
`default_nettype wire

// >>> sar_host_model.sv
// Comparator and host stand-in on the far side of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
    input  wire logic                     i_clk_sys,
    input  wire logic [11:0]              i_target,
    input  wire logic [11:0]              i_dac_trial,
    input  wire sar_seq_pkg::result_bus_t i_result,
    output logic                          o_comp_keep,
    output logic [11:0]                   o_captured
);
    logic busy_q;

    // Keep a trial bit while the trial does not exceed the held input.
    assign o_comp_keep = (i_dac_trial <= i_target);

    always_ff @(posedge i_clk_sys) begin
        busy_q <= i_result.busy;
        if (busy_q && !i_result.busy) o_captured <= i_result.data_n;
    end
endmodule
`default_nettype wire

// >>> sar_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_bench;
    logic                     i_clk_sys = 1'b0;
    logic                     i_nrst = 1'b0;
    logic                     i_convert_start = 1'b1;
    logic                     i_comp_keep;
    logic                     i_early_stop;
    sar_seq_pkg::result_bus_t o_result;
    logic [11:0]              o_dac_trial;
    logic                     o_gated_clk;
    logic                     o_busy;
    logic [11:0]              target = 12'h000;
    logic [11:0]              captured;
    logic [1:0]               mode = 2'h0;
    int                       errors = 0;
    int                       n_tests = 0;

    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    // Short cycle ties the stop input to a trial bit that is cleared late in the run.
    assign i_early_stop = (mode == 2'h1) ? o_result.data_n[1] :
                          (mode == 2'h2) ? o_result.data_n[3] : 1'b1;

    sar_conversion_sequencer DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_convert_start(i_convert_start), .i_comp_keep(i_comp_keep),
        .i_early_stop(i_early_stop), .o_result(o_result), .o_dac_trial(o_dac_trial),
        .o_gated_clk(o_gated_clk), .o_busy(o_busy));
    sar_host_model host (.i_clk_sys(i_clk_sys), .i_target(target), .i_dac_trial(o_dac_trial),
        .i_result(o_result), .o_comp_keep(i_comp_keep), .o_captured(captured));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Pulses start for eight cycles, well over the minimum width.
    task automatic pulse_start();
        @(posedge i_clk_sys) #2;
        i_convert_start = 1'b0;
        repeat (8) @(posedge i_clk_sys);
        #2;
        i_convert_start = 1'b1;
    endtask

    // One conversion; the wait is bounded by the allowed conversion time.
    task automatic convert(input logic [1:0] m, input logic [11:0] tgt,
                           input logic [11:0] truth, input int limit);
        int n;
        mode = m;
        target = tgt;
        pulse_start();
        check({15'h0, o_busy}, 16'h0001);
        n = 0;
        while (o_busy === 1'b1 && n < limit) begin
            @(posedge i_clk_sys) #2;
            n++;
        end
        check({15'h0, o_busy}, 16'h0000);
        if (o_busy !== 1'b0) complete_run();
        check({4'h0, o_result.data_n}, {4'h0, ~truth});
        check({15'h0, o_result.msb_inv}, {15'h0, truth[11]});
        repeat (2) @(posedge i_clk_sys) #2;
        check({3'h0, o_gated_clk, captured}, {4'h0, ~truth});
    endtask

    task automatic full_codes();
        logic [11:0] codes [4] = '{12'h676, 12'h000, 12'hFFF, 12'h800};
        foreach (codes[i]) convert(2'h0, codes[i], codes[i], 400);
    endtask

    // The bit after the last decision stays at its trial one; lower bits stay zero.
    task automatic short_cycles();
        convert(2'h1, 12'hABC, 12'hABE, 340);
        convert(2'h2, 12'hABC, 12'hAB8, 272);
    endtask

    task automatic reset_mid();
        mode = 2'h0;
        pulse_start();
        repeat (40) @(posedge i_clk_sys);
        #2;
        i_nrst = 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #2;
        check({o_busy, o_gated_clk, 2'h0, o_result.data_n}, 16'h0FFF);
        check({4'h0, o_dac_trial}, 16'h0000);
        i_nrst = 1'b1;
        repeat (4) @(posedge i_clk_sys);
    endtask

    initial begin
        repeat (10) @(posedge i_clk_sys);
        #2;
        i_nrst = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        full_codes();
        short_cycles();
        reset_mid();
        convert(2'h0, 12'h123, 12'h123, 400);
        complete_run();
    end
endmodule
`default_nettype wire
